// [dqr_config_reader.sv]
// Operation
// - wide mode: one shared clock, per-flash select and data, driven alike.
// - flash shifts on falling edge; device samples rising unless fall mode.
// - clock from internal divider at rate setting, or from external pin.
// - no downstream chaining while reading eight bits wide.
// - wide-mode switch issues quad read, 3 or 4 byte form, to both.
// - wide mode: after opening part each byte is primary low nibble, secondary high.
// - three address bytes with standard opcodes, four with the 4-byte quad read variant.
// - exactly one select line per flash; multi-select dies unsupported.
// - image read by one continuous command, or by two in wide mode with select high between them.
// - capture rising at start; falling only once the header bytes are read.
// - falling-edge capture takes effect before any clock source change.
// - device generates the serial clock at the configured rate, half period no less than MIN_HALF; the external-pin clock has no such floor.
// - at power-on start or restart: select low and send the read command.
// - first command is single-width fast read, 3-byte address zero.
module dqr_config_reader
    import dqr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_master_clock_in,
    output logic             cfg_serial_clock,
    output logic      [1:0]  flash_select_n,
    output logic      [1:0]  flash_mosi_out,
    output logic      [1:0]  flash_mosi_oe,
    input  wire logic [7:0]  flash_dq_in,
    output logic      [7:0]  stream_data,
    output logic             stream_valid,
    output logic             chain_data_out,
    output logic             config_done
);
    dqr_sck_if sif ();

    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] hdr_reg, hdr_next;
    logic [31:0] len_reg, len_next;
    logic [7:0]  dummy_reg, dummy_next;
    logic        restart_reg, restart_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic        wr_pend_reg, wr_pend_next;
    logic [11:0] wr_addr_reg, wr_addr_next;
    logic        addr_ok;
    logic [31:0] status_word;

    dqr_state_t  state_reg, state_next;
    logic [39:0] shift_reg, shift_next;
    logic [5:0]  cmd_len_reg, cmd_len_next;
    logic [7:0]  bit_cnt_reg, bit_cnt_next;
    logic [31:0] byte_cnt_reg, byte_cnt_next;
    logic [7:0]  cap_reg, cap_next;
    logic [3:0]  wait_reg, wait_next;
    logic        x8_reg, x8_next;
    logic        fall_cap_reg, fall_cap_next;
    logic        ext_act_reg, ext_act_next;
    logic [7:0]  half_reg, half_next;
    logic        switched_reg, switched_next;
    logic        skip_reg, skip_next;
    logic        run_reg, run_next;
    logic [1:0]  sel_n_reg, sel_n_next;
    logic [1:0]  mosi_reg, mosi_next;
    logic [1:0]  oe_reg, oe_next;
    logic [7:0]  data_reg, data_next;
    logic        valid_reg, valid_next;
    logic        chain_reg, chain_next;
    logic        done_reg, done_next;
    logic [7:0]  dq_s1_reg, dq_s2_reg, dq_s3_reg, dq_held_reg;
    logic [7:0]  dq_now;
    logic        cap_edge;
    logic        emit;
    logic [7:0]  emit_byte;
    logic [31:0] nbyte;

    dqr_sck_gen u_sck (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .ext_master_clock_in (ext_master_clock_in),
        .sif                 (sif)
    );

    assign sif.half_period = half_reg;
    assign sif.ext_sel     = ext_act_reg;
    assign sif.run         = run_reg;

    assign hrdata           = hrdata_reg;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign cfg_serial_clock = sif.sck;
    assign flash_select_n   = sel_n_reg;
    assign flash_mosi_out   = mosi_reg;
    assign flash_mosi_oe    = oe_reg;
    assign stream_data      = data_reg;
    assign stream_valid     = valid_reg;
    assign chain_data_out   = chain_reg;
    assign config_done      = done_reg;

    ////////////////////////////////////////////////////////////////////////
    // register bus, zero wait states
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STS_BUSY_BIT] = (state_reg != ST_DONE);
        status_word[STS_X8_BIT]   = x8_reg;
        status_word[STS_FALL_BIT] = fall_cap_reg;
        status_word[STS_EXT_BIT]  = ext_act_reg;
        status_word[STS_DONE_BIT] = done_reg;
        status_word[STS_BYTE_LSB +: 8] = data_reg;
        ctrl_next    = ctrl_reg;
        hdr_next     = hdr_reg;
        len_next     = len_reg;
        dummy_next   = dummy_reg;
        restart_next = 1'b0;
        hrdata_next  = hrdata_reg;
        wr_pend_next = addr_ok && hwrite;
        wr_addr_next = haddr[11:0];
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                OFS_CTRL: begin
                    ctrl_next = hwdata;
                    ctrl_next[CTL_RESTART_BIT] = 1'b0;
                    restart_next = hwdata[CTL_RESTART_BIT];
                end
                OFS_HDR:   hdr_next   = hwdata;
                OFS_LEN:   len_next   = hwdata;
                OFS_DUMMY: dummy_next = hwdata[7:0];
                default: ;
            endcase
        end
        if (addr_ok && !hwrite) begin
            case (haddr[11:0])
                OFS_CTRL:   hrdata_next = ctrl_reg;
                OFS_HDR:    hrdata_next = hdr_reg;
                OFS_LEN:    hrdata_next = len_reg;
                OFS_DUMMY:  hrdata_next = {24'h00_0000, dummy_reg};
                OFS_STATUS: hrdata_next = status_word;
                OFS_COUNT:  hrdata_next = byte_cnt_reg;
                default:    hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg    <= {16'h0000, RST_RATE, 8'h00};
            hdr_reg     <= RST_HDR;
            len_reg     <= RST_LEN;
            dummy_reg   <= RST_DUMMY;
            restart_reg <= 1'b0;
            hrdata_reg  <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            ctrl_reg    <= ctrl_next;
            hdr_reg     <= hdr_next;
            len_reg     <= len_next;
            dummy_reg   <= dummy_next;
            restart_reg <= restart_next;
            hrdata_reg  <= hrdata_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read engine
    assign dq_now   = dqr_settle(dq_s2_reg, dq_s3_reg, dq_held_reg);
    assign cap_edge = fall_cap_reg ? sif.fall : sif.rise;
    assign nbyte    = byte_cnt_reg + 32'h0000_0001;

    always_comb begin
        state_next    = state_reg;
        shift_next    = shift_reg;
        cmd_len_next  = cmd_len_reg;
        bit_cnt_next  = bit_cnt_reg;
        byte_cnt_next = byte_cnt_reg;
        cap_next      = cap_reg;
        wait_next     = wait_reg;
        x8_next       = x8_reg;
        fall_cap_next = fall_cap_reg;
        ext_act_next  = ext_act_reg;
        half_next     = half_reg;
        switched_next = switched_reg;
        skip_next     = skip_reg;
        run_next      = run_reg;
        sel_n_next    = sel_n_reg;
        mosi_next     = mosi_reg;
        oe_next       = oe_reg;
        data_next     = data_reg;
        chain_next    = chain_reg;
        done_next     = done_reg;
        valid_next    = 1'b0;
        emit          = 1'b0;
        emit_byte     = cap_reg;
        unique case (state_reg)
            ST_BOOT: begin
                shift_next   = {OP_FAST_READ, 32'h0000_0000};
                cmd_len_next = CMD_BITS_3B;
                bit_cnt_next = 8'h00;
                sel_n_next   = 2'b10;
                oe_next      = 2'b01;
                mosi_next    = {1'b0, OP_FAST_READ[7]};
                run_next     = 1'b1;
                state_next   = ST_CMD;
            end
            ST_CMD: begin
                if (sif.rise) begin
                    bit_cnt_next = bit_cnt_reg + 8'h01;
                    if (bit_cnt_reg[5:0] + 6'h01 == cmd_len_reg) begin
                        bit_cnt_next = 8'h00;
                        oe_next      = 2'b00;
                        state_next   = ST_DUMMY;
                    end
                end else if (sif.fall) begin
                    shift_next = {shift_reg[38:0], 1'b0};
                    mosi_next  = {x8_reg & shift_reg[38], shift_reg[38]};
                end
            end
            ST_DUMMY: begin
                if (sif.rise) begin
                    bit_cnt_next = bit_cnt_reg + 8'h01;
                    if (bit_cnt_reg + 8'h01 >= dummy_reg) begin
                        bit_cnt_next = 8'h00;
                        skip_next    = fall_cap_reg;
                        state_next   = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (cap_edge && skip_reg) begin
                    skip_next = 1'b0;
                end else if (cap_edge && x8_reg) begin
                    emit      = 1'b1;
                    emit_byte = dq_now;
                end else if (cap_edge) begin
                    cap_next     = {cap_reg[6:0], dq_now[1]};
                    chain_next   = dq_now[1];
                    bit_cnt_next = {5'h00, bit_cnt_reg[2:0] + 3'h1};
                    emit         = (bit_cnt_reg[2:0] == 3'h7);
                    emit_byte    = {cap_reg[6:0], dq_now[1]};
                end
            end
            ST_FALLSET: begin
                run_next = 1'b0;
                if (!sif.sck && !run_reg) begin
                    fall_cap_next = ctrl_reg[CTL_FALL_BIT];
                    switched_next = 1'b1;
                    state_next    = ST_CLKSET;
                end
            end
            ST_CLKSET: begin
                half_next    = ctrl_reg[CTL_RATE_LSB +: 8];
                ext_act_next = ctrl_reg[CTL_EXT_BIT];
                if (ctrl_reg[CTL_X8_BIT]) begin
                    x8_next    = 1'b1;
                    sel_n_next = 2'b11;
                    oe_next    = 2'b00;
                    wait_next  = DESEL_CYCLES;
                    state_next = ST_DESEL;
                end else begin
                    skip_next  = 1'b0;
                    run_next   = 1'b1;
                    state_next = ST_DATA;
                end
            end
            ST_DESEL: begin
                wait_next = wait_reg - 4'h1;
                if (wait_reg == 4'h0) begin
                    if (ctrl_reg[CTL_ADDR4_BIT]) begin
                        shift_next   = {OP_QUAD_READ4, hdr_reg};
                        cmd_len_next = CMD_BITS_4B;
                    end else begin
                        shift_next   = {OP_QUAD_READ, hdr_reg[23:0], 8'h00};
                        cmd_len_next = CMD_BITS_3B;
                    end
                    mosi_next    = ctrl_reg[CTL_ADDR4_BIT] ?
                                   {2{OP_QUAD_READ4[7]}} : {2{OP_QUAD_READ[7]}};
                    bit_cnt_next = 8'h00;
                    sel_n_next   = 2'b00;
                    oe_next      = 2'b11;
                    chain_next   = 1'b1;
                    run_next     = 1'b1;
                    state_next   = ST_CMD;
                end
            end
            ST_DONE: begin
                run_next   = 1'b0;
                sel_n_next = 2'b11;
                oe_next    = 2'b00;
                done_next  = 1'b1;
                if (restart_reg) begin
                    x8_next       = 1'b0;
                    fall_cap_next = 1'b0;
                    ext_act_next  = 1'b0;
                    half_next     = BOOT_HALF;
                    switched_next = 1'b0;
                    byte_cnt_next = 32'h0000_0000;
                    done_next     = 1'b0;
                    state_next    = ST_BOOT;
                end
            end
        endcase
        if (emit) begin
            data_next     = emit_byte;
            valid_next    = 1'b1;
            byte_cnt_next = nbyte;
            if (x8_reg) begin
                chain_next = 1'b1;
            end
            if (nbyte == len_reg) begin
                run_next   = 1'b0;
                state_next = ST_DONE;
            end else if (nbyte == hdr_reg && !switched_reg) begin
                run_next   = 1'b0;
                state_next = ST_FALLSET;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= ST_BOOT;
            shift_reg    <= 40'h00_0000_0000;
            cmd_len_reg  <= CMD_BITS_3B;
            bit_cnt_reg  <= 8'h00;
            byte_cnt_reg <= 32'h0000_0000;
            cap_reg      <= 8'h00;
            wait_reg     <= 4'h0;
            x8_reg       <= 1'b0;
            fall_cap_reg <= 1'b0;
            ext_act_reg  <= 1'b0;
            half_reg     <= BOOT_HALF;
            switched_reg <= 1'b0;
            skip_reg     <= 1'b0;
            run_reg      <= 1'b0;
            sel_n_reg    <= 2'b11;
            mosi_reg     <= 2'b00;
            oe_reg       <= 2'b00;
            data_reg     <= 8'h00;
            valid_reg    <= 1'b0;
            chain_reg    <= 1'b1;
            done_reg     <= 1'b0;
            dq_s1_reg    <= 8'h00;
            dq_s2_reg    <= 8'h00;
            dq_s3_reg    <= 8'h00;
            dq_held_reg  <= 8'h00;
        end else begin
            state_reg    <= state_next;
            shift_reg    <= shift_next;
            cmd_len_reg  <= cmd_len_next;
            bit_cnt_reg  <= bit_cnt_next;
            byte_cnt_reg <= byte_cnt_next;
            cap_reg      <= cap_next;
            wait_reg     <= wait_next;
            x8_reg       <= x8_next;
            fall_cap_reg <= fall_cap_next;
            ext_act_reg  <= ext_act_next;
            half_reg     <= half_next;
            switched_reg <= switched_next;
            skip_reg     <= skip_next;
            run_reg      <= run_next;
            sel_n_reg    <= sel_n_next;
            mosi_reg     <= mosi_next;
            oe_reg       <= oe_next;
            data_reg     <= data_next;
            valid_reg    <= valid_next;
            chain_reg    <= chain_next;
            done_reg     <= done_next;
            dq_s1_reg    <= flash_dq_in;
            dq_s2_reg    <= dq_s1_reg;
            dq_s3_reg    <= dq_s2_reg;
            dq_held_reg  <= dq_now;
        end
    end

endmodule

// [dqr_config_reader_monitor.sv]
module dqr_config_reader_monitor (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       cfg_serial_clock,
    input wire logic [1:0] flash_select_n,
    input wire logic [1:0] flash_mosi_out,
    input wire logic [1:0] flash_mosi_oe,
    input wire logic       stream_valid,
    input wire logic       chain_data_out,
    input wire logic       config_done
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_twins_alike: assert property (!flash_select_n[1] |->
        {flash_select_n[0], flash_mosi_out[1], flash_mosi_oe[1]} ==
        {1'b0, flash_mosi_out[0], flash_mosi_oe[0]}) else $error("unalike");
    a_half_min: assert property ($changed(cfg_serial_clock) |=>
        $stable(cfg_serial_clock) [*3]) else $error("short half");
    a_chain_idle: assert property (!flash_select_n[1] |->
        chain_data_out) else $error("chain active");
    a_one_command: assert property ($rose(flash_select_n[0]) |->
        ##[0:12] (config_done || flash_select_n == 2'b00)) else $error("split");
    a_first_bit: assert property ($fell(flash_select_n[0]) |->
        flash_mosi_oe[0] && !flash_mosi_out[0]) else $error("first bit");
    a_drive_sel: assert property (
        (flash_mosi_oe & flash_select_n) == 2'b00) else $error("stray drive");
    a_mosi_low: assert property ($changed(flash_mosi_out) |->
        !cfg_serial_clock) else $error("moved high");
    a_byte_gap: assert property (stream_valid |=>
        !stream_valid [*3]) else $error("byte early");
endmodule
bind dqr_config_reader dqr_config_reader_monitor dqr_config_reader_monitor_i (
    .hclk, .hresetn, .cfg_serial_clock, .flash_select_n, .flash_mosi_out,
    .flash_mosi_oe, .stream_valid, .chain_data_out, .config_done);

// [dqr_flash.sv]
module dqr_flash #(
    parameter int DUMMY = 8
) (
    input wire logic       sck,
    input wire logic [1:0] sel_n,
    input wire logic [1:0] mosi,
    input wire logic [1:0] oe,
    output logic     [7:0] dq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  mem [2][16];
    logic [7:0]  op  [2];
    logic [31:0] ad  [2];
    logic [39:0] sh  [2];
    logic [3:0]  nib [2] = '{4'h5, 4'hA};
    int          cnt [2] = '{0, 0};
    int          ln  [2];
    int          i;
    always @(sel_n) for (int k = 0; k < 2; k++) if (sel_n[k]) cnt[k] = 0;
    always @(posedge sck) for (int k = 0; k < 2; k++) if (!sel_n[k]) begin
        cnt[k]++;
        sh[k] = {sh[k][38:0], mosi[k]};
        if (cnt[k] == 8) op[k] = sh[k][7:0];
        if (cnt[k] == 8) ln[k] = sh[k][7:0] == 8'h6C ? 40 : 32;
        if (cnt[k] == ln[k]) ad[k] = sh[k][31:0];
        if (ln[k] == 32) ad[k][31:24] = 8'h00;
    end
    // data launched on the falling edge
    always @(negedge sck) for (int k = 0; k < 2; k++) begin
        i = cnt[k] - ln[k] - DUMMY;
        if (sel_n[k] || i < 0) nib[k] = ~nib[k];
        else if (op[k] == 8'h0B)
            nib[k] = {2'b00, mem[k][ad[k] + i / 8][7 - i % 8], 1'b0};
        else
            nib[k] = mem[k][ad[k] + i / 2] >> (i % 2 ? 0 : 4);
    end
    for (genvar k = 0; k < 2; k++) begin : g_pin
        assign dq[k*4+:4] = sel_n[k] ? ~nib[k] :
                            oe[k] ? {nib[k][3:1], mosi[k]} : nib[k];
    end
endmodule

// [dqr_pkg.sv]
package dqr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // flash read opcodes
    localparam logic [7:0] OP_FAST_READ  = 8'h0B;
    localparam logic [7:0] OP_QUAD_READ  = 8'h6B;
    localparam logic [7:0] OP_QUAD_READ4 = 8'h6C;

    // command plus address bit counts
    localparam logic [5:0] CMD_BITS_3B = 6'h20;
    localparam logic [5:0] CMD_BITS_4B = 6'h28;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_HDR    = 12'h004;
    localparam logic [11:0] OFS_LEN    = 12'h008;
    localparam logic [11:0] OFS_DUMMY  = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_COUNT  = 12'h014;

    // control fields
    localparam int CTL_X8_BIT      = 0;
    localparam int CTL_ADDR4_BIT   = 1;
    localparam int CTL_FALL_BIT    = 2;
    localparam int CTL_EXT_BIT     = 3;
    localparam int CTL_RATE_LSB    = 8;
    localparam int CTL_RESTART_BIT = 31;

    // status fields
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_X8_BIT   = 1;
    localparam int STS_FALL_BIT = 2;
    localparam int STS_EXT_BIT  = 3;
    localparam int STS_DONE_BIT = 4;
    localparam int STS_BYTE_LSB = 8;

    ////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0]  RST_RATE  = 8'h04;
    localparam logic [31:0] RST_HDR   = 32'h0000_0100;
    localparam logic [31:0] RST_LEN   = 32'h0001_0000;
    localparam logic [7:0]  RST_DUMMY = 8'h08;

    // half periods of the serial clock, in hclk cycles
    localparam logic [7:0] BOOT_HALF = 8'h04;
    localparam logic [7:0] MIN_HALF  = 8'h04;

    // select high time between the two read commands
    localparam logic [3:0] DESEL_CYCLES = 4'h8;

    typedef enum {
        ST_BOOT, ST_CMD, ST_DUMMY, ST_DATA,
        ST_FALLSET, ST_CLKSET, ST_DESEL, ST_DONE
    } dqr_state_t;

    // per bit: take the new level once stages two and three agree
    function automatic logic [7:0] dqr_settle(input logic [7:0] s2,
                                              input logic [7:0] s3,
                                              input logic [7:0] held);
        return (s2 & s3) | (held & (s2 ^ s3));
    endfunction

endpackage

// [dqr_sck_gen.sv]
module dqr_sck_gen
    import dqr_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ext_master_clock_in,
    dqr_sck_if.gen    sif
);
    logic [2:0] ext_sync_reg, ext_sync_next;
    logic       ext_held_reg, ext_held_next;
    logic [7:0] div_reg, div_next;
    logic       sck_reg, sck_next;
    logic       rise_reg, rise_next;
    logic       fall_reg, fall_next;
    logic [7:0] half;
    logic [7:0] settled;

    assign sif.sck  = sck_reg;
    assign sif.rise = rise_reg;
    assign sif.fall = fall_reg;

    ////////////////////////////////////////////////////////////////////////
    // divider or external edge follower; stops only at the low level
    always_comb begin
        half = (sif.half_period < MIN_HALF) ? MIN_HALF : sif.half_period;
        settled = dqr_settle({7'h00, ext_sync_reg[1]},
                             {7'h00, ext_sync_reg[2]},
                             {7'h00, ext_held_reg});
        ext_sync_next = {ext_sync_reg[1:0], ext_master_clock_in};
        ext_held_next = settled[0];
        div_next      = div_reg;
        sck_next      = sck_reg;
        rise_next     = 1'b0;
        fall_next     = 1'b0;
        if (sif.ext_sel) begin
            div_next = 8'h00;
            if (ext_held_next && !ext_held_reg && sif.run && !sck_reg) begin
                sck_next  = 1'b1;
                rise_next = 1'b1;
            end else if (!ext_held_next && ext_held_reg && sck_reg) begin
                sck_next  = 1'b0;
                fall_next = 1'b1;
            end
        end else if (div_reg >= half - 8'h01) begin
            div_next = 8'h00;
            if (sck_reg) begin
                sck_next  = 1'b0;
                fall_next = 1'b1;
            end else if (sif.run) begin
                sck_next  = 1'b1;
                rise_next = 1'b1;
            end
        end else begin
            div_next = div_reg + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_sync_reg <= 3'h0;
            ext_held_reg <= 1'b0;
            div_reg      <= 8'h00;
            sck_reg      <= 1'b0;
            rise_reg     <= 1'b0;
            fall_reg     <= 1'b0;
        end else begin
            ext_sync_reg <= ext_sync_next;
            ext_held_reg <= ext_held_next;
            div_reg      <= div_next;
            sck_reg      <= sck_next;
            rise_reg     <= rise_next;
            fall_reg     <= fall_next;
        end
    end

endmodule

// [dqr_sck_if.sv]
interface dqr_sck_if;
    logic [7:0] half_period;
    logic       ext_sel;
    logic       run;
    logic       sck;
    logic       rise;
    logic       fall;

    modport gen  (input  half_period, ext_sel, run,
                  output sck, rise, fall);
    modport user (output half_period, ext_sel, run,
                  input  sck, rise, fall);
endinterface

// [tb_dqr_config_reader.sv]
module tb_dqr_config_reader
    import dqr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 0, hresetn = 0, hwrite = 0, ext_master_clock_in = 0;
    logic        hreadyout, hresp, cfg_serial_clock, stream_valid;
    logic        chain_data_out, config_done;
    logic [1:0]  htrans = 0, flash_select_n, flash_mosi_out, flash_mosi_oe;
    logic [7:0]  flash_dq_in, stream_data, b0, b1, e;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [7:0]  got [$];
    int          fail_count = 0;
    int          compares = 0;
    dqr_config_reader dqr_config_reader_i (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .ext_master_clock_in, .cfg_serial_clock, .flash_select_n,
        .flash_mosi_out, .flash_mosi_oe, .flash_dq_in, .stream_data,
        .stream_valid, .chain_data_out, .config_done);
    dqr_flash dqr_flash_i (.sck(cfg_serial_clock), .sel_n(flash_select_n),
        .mosi(flash_mosi_out), .oe(flash_mosi_oe), .dq(flash_dq_in));
    initial forever #20 hclk = ~hclk;
    initial #7 forever #160 ext_master_clock_in = ~ext_master_clock_in;
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        conclude();
    end
    always @(negedge hclk) if (stream_valid === 1'b1) got.push_back(stream_data);
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED %0t: %h not %h", $time, seen, want);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(43295));
        foreach (dqr_flash_i.mem[k, a]) dqr_flash_i.mem[k][a] = 8'($urandom);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, OFS_CTRL, 0);
        check(r, 32'h0000_0400);
        bus(0, 12'h020, 0);
        check(r, 32'h0);
        for (int m = 0; m < 2; m++) begin
            got = {};
            bus(1, OFS_HDR, 4);
            bus(1, OFS_LEN, 12);
            bus(1, OFS_CTRL, m ? 32'h8000_050F : 32'h0000_0401);
            for (int t = 0; t < 9000 && (got.size() < 12 || !config_done); t++)
                @(posedge hclk);
            for (int i = 0; i < 12; i++) begin
                b0 = dqr_flash_i.mem[0][i < 4 ? i : 2 + i / 2];
                b1 = dqr_flash_i.mem[1][2 + i / 2];
                e = i < 4 ? b0 : i % 2 ? {b1[3:0], b0[3:0]} : {b1[7:4], b0[7:4]};
                check(got[i], e);
            end
            check(got.size(), 12);
            check(dqr_flash_i.op[1], m ? 8'h6C : 8'h6B);
            check(dqr_flash_i.ad[1], 4);
            bus(0, OFS_STATUS, 0);
            check(r[15:0], {e, 3'h0, 1'b1, 2'(m * 3), 2'h2});
            bus(0, OFS_COUNT, 0);
            check(r, 32'd12);
            check(hresp, 1'b0);
            $display("mode %0d finished", m);
        end
        conclude();
    end
endmodule
